/* design/pcl_pkg.sv */
// Purpose: Constants and types for the parallel configuration loader
// Assumes: 100 MHz system clock, host clock sampled as a plain input
// Notes: Ratio of one host clock cycle per data word
package pcl_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_DELAY_US = 100;
   localparam int POR_CYCLES = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_FALL_EDGES = 2;

   // Image layout
   localparam int IMAGE_WORDS_DEF = 16;
   localparam int OPT_INIT_DONE_BIT = 0;
   localparam int DATA_PINS = 32;
   localparam int WORD_BITS = 16;
   localparam int BYTE_BITS = 8;

   // Loader states
   typedef enum logic [4:0] {
      ST_POR = 5'h01,
      ST_HOLD = 5'h02,
      ST_LOAD = 5'h04,
      ST_INIT = 5'h08,
      ST_USER = 5'h10
   } pcl_state_t;

   // Pins from the host
   typedef struct packed {
      logic request_n;
      logic clk;
      logic wide16;
      logic [DATA_PINS-1:0] data;
   } pcl_pins_t;

   // Word handed to the configuration memory
   typedef struct packed {
      logic valid;
      logic wide16;
      logic [WORD_BITS-1:0] data;
   } pcl_word_t;

endpackage : pcl_pkg

/* design/pcl_sync.sv */
// Purpose: Two-stage synchroniser for host pins
// Assumes: Inputs asynchronous to clock_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module pcl_sync
   import pcl_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Two flops in series
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule : pcl_sync

/* design/pcl_loader.sv */
// Purpose: Fast passive parallel configuration port, one word per host clock
// Assumes: Host clock far slower than clock_i, sampled and edge detected
// Notes: Image length fixed by parameter, last word carries the option bit
`timescale 1ns/1ns
module pcl_loader
   import pcl_pkg::*;
#(
   parameter int IMAGE_WORDS = IMAGE_WORDS_DEF,
   parameter int POR_COUNT = POR_CYCLES
)
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic config_request_n_i,
   input wire logic config_clock_i,
   input wire logic wide16_i,
   input wire logic [DATA_PINS-1:0] data_i,
   output logic config_status_n_o,
   output logic config_complete_o,
   output logic init_done_o,
   output logic init_done_oe_n_o,
   output logic user_io_en_o,
   output logic user_mode_o,
   output pcl_word_t cfg_word_o
);

   localparam int CW = $clog2(IMAGE_WORDS + 1);
   localparam int PW = $clog2(POR_COUNT + 1);
   localparam logic [CW-1:0] LAST_WORD = CW'(IMAGE_WORDS - 1);
   localparam logic [PW-1:0] POR_LAST = PW'(POR_COUNT - 1);
   localparam logic [1:0] FALL_LAST = 2'(INIT_FALL_EDGES - 1);

   pcl_pins_t pins_raw;
   pcl_pins_t pins_s;
   logic clk_prev_q;
   logic clk_rise;
   logic clk_fall;

   pcl_state_t state_q, state_d;
   logic [PW-1:0] por_cnt_q, por_cnt_d;
   logic [CW-1:0] word_cnt_q, word_cnt_d;
   logic [1:0] fall_cnt_q, fall_cnt_d;
   logic opt_q, opt_d;
   pcl_word_t word_q, word_d;
   logic status_q, status_d;
   logic complete_q, complete_d;
   logic user_q, user_d;
   logic init_oe_n_q, init_oe_n_d;

   // Host pins into the clock domain
   assign pins_raw = '{request_n: config_request_n_i, clk: config_clock_i,
                       wide16: wide16_i, data: data_i};

   pcl_sync #(.WIDTH($bits(pcl_pins_t))) u_sync (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   // Edge detect on the synchronised host clock
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         clk_prev_q <= 1'b0;
      end
      else
      begin
         clk_prev_q <= pins_s.clk;
      end
   end

   assign clk_rise = pins_s.clk & ~clk_prev_q;
   assign clk_fall = ~pins_s.clk & clk_prev_q;

   // Next state, counters and captured words
   always_comb
   begin
      state_d = state_q;
      por_cnt_d = por_cnt_q;
      word_cnt_d = word_cnt_q;
      fall_cnt_d = fall_cnt_q;
      opt_d = opt_q;
      word_d = '0;
      unique case (state_q)
         ST_POR:
         begin
            por_cnt_d = por_cnt_q + 1'b1;
            if (por_cnt_q == POR_LAST)
            begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            word_cnt_d = '0;
            fall_cnt_d = '0;
            opt_d = 1'b0;
            if (pins_s.request_n)
            begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD:
         begin
            if (!pins_s.request_n)
            begin
               state_d = ST_HOLD;
            end
            else if (clk_rise)
            begin
               word_d.valid = 1'b1;
               word_d.wide16 = pins_s.wide16;
               word_d.data = pins_s.wide16 ? pins_s.data[WORD_BITS-1:0]
                  : {{(WORD_BITS-BYTE_BITS){1'b0}}, pins_s.data[BYTE_BITS-1:0]};
               word_cnt_d = word_cnt_q + 1'b1;
               if (word_cnt_q == LAST_WORD)
               begin
                  opt_d = pins_s.data[OPT_INIT_DONE_BIT];
                  state_d = ST_INIT;
               end
            end
         end
         ST_INIT:
         begin
            if (!pins_s.request_n)
            begin
               state_d = ST_HOLD;
            end
            else if (clk_fall)
            begin
               fall_cnt_d = fall_cnt_q + 1'b1;
               if (fall_cnt_q == FALL_LAST)
               begin
                  state_d = ST_USER;
               end
            end
         end
         ST_USER:
         begin
            if (!pins_s.request_n)
            begin
               state_d = ST_HOLD;
            end
         end
         default:
         begin
            state_d = ST_POR;
         end
      endcase
   end

   // Pin levels follow the next state so they line up with state_q
   always_comb
   begin
      status_d = !(state_d == ST_POR || state_d == ST_HOLD);
      complete_d = (state_d == ST_INIT) || (state_d == ST_USER);
      user_d = (state_d == ST_USER);
      init_oe_n_d = !((state_d == ST_INIT) && opt_d);
   end

   // Registers
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q <= ST_POR;
         por_cnt_q <= '0;
         word_cnt_q <= '0;
         fall_cnt_q <= 2'h0;
         opt_q <= 1'b0;
         word_q <= '0;
         status_q <= 1'b0;
         complete_q <= 1'b0;
         user_q <= 1'b0;
         init_oe_n_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         por_cnt_q <= por_cnt_d;
         word_cnt_q <= word_cnt_d;
         fall_cnt_q <= fall_cnt_d;
         opt_q <= opt_d;
         word_q <= word_d;
         status_q <= status_d;
         complete_q <= complete_d;
         user_q <= user_d;
         init_oe_n_q <= init_oe_n_d;
      end
   end

   // Outputs straight from flops, except init_done_o which is tied low
   assign config_status_n_o = status_q;
   assign config_complete_o = complete_q;
   assign init_done_o = 1'b0 & init_oe_n_q;
   assign init_done_oe_n_o = init_oe_n_q;
   assign user_io_en_o = user_q;
   assign user_mode_o = user_q;
   assign cfg_word_o = word_q;

   // Checks
   sequence s_last_word;
      state_q == ST_LOAD && pins_s.request_n && clk_rise && word_cnt_q == LAST_WORD;
   endsequence

   sequence s_second_fall;
      state_q == ST_INIT && pins_s.request_n && clk_fall && fall_cnt_q == FALL_LAST;
   endsequence

   a_user_abort: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == ST_USER && !pins_s.request_n |=> state_q == ST_HOLD && !status_q)
      else $error("request low in user mode did not restart the load");

   a_user_levels: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == ST_USER |-> status_q && complete_q && user_io_en_o)
      else $error("status or complete not high in user mode");

   a_por_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == ST_POR |-> !status_q && por_cnt_q <= POR_LAST)
      else $error("status released during power-on delay");

   a_complete_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q inside {ST_POR, ST_HOLD, ST_LOAD} |-> !complete_q)
      else $error("complete high before load finished");

   a_word_capture: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == ST_LOAD && pins_s.request_n && clk_rise
      |=> word_q.valid && word_q.data[BYTE_BITS-1:0] == $past(pins_s.data[BYTE_BITS-1:0]))
      else $error("data word not captured on rising host clock");

   a_byte_mode: assert property (@(posedge clock_i) disable iff (!rstn_i)
      word_q.valid && !word_q.wide16 |-> word_q.data[WORD_BITS-1:BYTE_BITS] == 8'h00)
      else $error("upper byte leaked in narrow mode");

   a_done_last: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_last_word |=> complete_q && state_q == ST_INIT ##1 !user_q)
      else $error("complete not raised after the last word");

   a_done_rise: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(complete_q) |-> $past(word_cnt_q) == LAST_WORD)
      else $error("complete raised before all words");

   a_two_falls: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_second_fall |=> user_q && user_io_en_o)
      else $error("user mode not entered after two falling edges");

   a_clock_ignored: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == ST_USER && pins_s.request_n |=> state_q == ST_USER && !word_q.valid)
      else $error("host clock acted on in user mode");

   a_init_drive: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == ST_INIT && opt_q |-> !init_done_oe_n_o ##0 !user_q)
      else $error("init done not driven low during initialisation");

endmodule : pcl_loader

/* dv/pcl_host_model.sv */
// Purpose: Host model driving the parallel configuration pins
// Assumes: Host clock of 124 ns period per word, parked low between frames
// Notes: Idle data lines show the inverse of the last word
`timescale 1ns/1ns
module pcl_host_model
   import pcl_pkg::*;
(
   output logic request_n_o,
   output logic clk_o,
   output logic wide16_o,
   output logic [DATA_PINS-1:0] data_o
);
   // Pins at rest, request released
   initial
   begin
      request_n_o = 1'b1;
      clk_o = 1'b0;
      wide16_o = 1'b1;
      data_o = '0;
   end

   // Drive the configuration request level
   task automatic set_request(input logic v);
      request_n_o = v;
   endtask : set_request

   // One word per host clock, set while low, held over the rise
   // Pin changes land off the system clock edges, so no sampling race
   task automatic send_word(input logic [DATA_PINS-1:0] w, input logic wide);
      #1 wide16_o = wide;
      data_o = w;
      #62 clk_o = 1'b1;
      #60 clk_o = 1'b0;
      data_o = ~w; // Released lines no longer hold the word
      #1;
   endtask : send_word

   // Bare clock pulse with no data, one falling edge, off system edges
   task automatic pulse();
      #63 clk_o = 1'b1;
      #60 clk_o = 1'b0;
      #2;
   endtask : pulse
endmodule : pcl_host_model

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the parallel configuration loader
// Assumes: Short power-on count of 8 and image of 4 words
// Notes: Host pins come from the host model
`timescale 1ns/1ns
module tb_top
   import pcl_pkg::*;
;
   logic clock_i;
   logic rstn_i;
   logic req_n, hclk, wide16;
   logic [DATA_PINS-1:0] data;
   logic status_n, complete, idone, idone_oe_n, io_en, user;
   pcl_word_t word;
   logic [16:0] got_q[$];
   int err_count = 0;
   int n_compared = 0;

   pcl_loader #(.IMAGE_WORDS(4), .POR_COUNT(8)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i),
      .config_request_n_i(req_n), .config_clock_i(hclk), .wide16_i(wide16), .data_i(data),
      .config_status_n_o(status_n), .config_complete_o(complete), .init_done_o(idone),
      .init_done_oe_n_o(idone_oe_n), .user_io_en_o(io_en), .user_mode_o(user),
      .cfg_word_o(word));
   pcl_host_model u_host (.request_n_o(req_n), .clk_o(hclk), .wide16_o(wide16),
      .data_o(data));

   // System clock
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Collect every word handed on, sampled where it has settled
   always @(negedge clock_i)
   begin
      if (word.valid === 1'b1) got_q.push_back({word.wide16, word.data});
   end

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic chk_bit(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic chk_word(input string name, input logic [16:0] exp, input logic [16:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_word

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock_i);
   endtask : wait_clk

   // Send n words, check each captured word and the width handling
   task automatic load_image(input logic wide, input logic opt, input logic [15:0] base,
      input int n);
      logic [31:0] w;
      logic [16:0] exp_a[8];
      got_q.delete();
      for (int i = 0; i < n; i++)
      begin
         w = {16'hc3c3 ^ 16'(i), base + 16'(i)};
         if (i == n - 1) w[0] = opt;
         exp_a[i] = wide ? {1'b1, w[15:0]} : {1'b0, 8'h00, w[7:0]};
         #1 chk_bit("complete early", 1'b0, complete);
         u_host.send_word(w, wide);
      end
      wait_clk(10);
      chk_bit("word count", 1'b1, got_q.size() == n);
      for (int i = 0; i < n && i < got_q.size(); i++)
         chk_word("word", exp_a[i], got_q[i]);
   endtask : load_image

   task automatic test_por();
      wait_clk(2);
      chk_bit("status in por", 1'b0, status_n);
      chk_bit("complete in por", 1'b0, complete);
      wait_clk(20);
      chk_bit("status after por", 1'b1, status_n);
   endtask : test_por

   // Full wide image with option, then exactly two falls to user mode
   task automatic test_wide(input logic opt);
      load_image(1'b1, opt, 16'h1230, 4);
      chk_bit("complete", 1'b1, complete);
      chk_bit("init oe_n", !opt, idone_oe_n);
      chk_bit("init value", 1'b0, idone);
      chk_bit("user after one fall", 1'b0, user);
      u_host.pulse();
      wait_clk(10);
      chk_bit("user", 1'b1, user);
      chk_bit("io released", 1'b1, io_en);
      chk_bit("status user", 1'b1, status_n);
      chk_bit("complete user", 1'b1, complete);
      chk_bit("init oe_n user", 1'b1, idone_oe_n);
   endtask : test_wide

   task automatic test_ignore_clock();
      got_q.delete();
      repeat (3) u_host.pulse();
      wait_clk(10);
      chk_bit("words in user", 1'b0, got_q.size() != 0);
      chk_bit("user kept", 1'b1, user);
   endtask : test_ignore_clock

   // Request low in user mode restarts, then a narrow image
   task automatic test_restart();
      u_host.set_request(1'b0);
      wait_clk(6);
      chk_bit("status restart", 1'b0, status_n);
      chk_bit("complete restart", 1'b0, complete);
      chk_bit("user restart", 1'b0, user);
      u_host.set_request(1'b1);
      wait_clk(10);
      load_image(1'b0, 1'b0, 16'h5a70, 4);
      chk_bit("complete narrow", 1'b1, complete);
      chk_bit("no init drive", 1'b1, idone_oe_n);
      u_host.pulse();
      wait_clk(10);
      chk_bit("user narrow", 1'b1, user);
   endtask : test_restart

   // Short image never completes; an abort clears the count for a full reload
   task automatic test_partial();
      u_host.set_request(1'b0);
      wait_clk(6);
      u_host.set_request(1'b1);
      wait_clk(10);
      load_image(1'b1, 1'b1, 16'h0ff0, 3);
      wait_clk(10);
      chk_bit("partial complete", 1'b0, complete);
      chk_bit("partial user", 1'b0, user);
      u_host.set_request(1'b0);
      wait_clk(6);
      chk_bit("partial abort status", 1'b0, status_n);
      u_host.set_request(1'b1);
      wait_clk(10);
      load_image(1'b1, 1'b1, 16'h2460, 4);
      chk_bit("reload complete", 1'b1, complete);
      chk_bit("reload init oe_n", 1'b0, idone_oe_n);
   endtask : test_partial

   // Main sequence
   initial
   begin
      rstn_i = 1'b0;
      wait_clk(20);
      rstn_i = 1'b1;
      test_por();
      test_wide(1'b1);
      test_ignore_clock();
      test_restart();
      test_partial();
      give_verdict();
   end

   // Watchdog
   initial
   begin
      #100000;
      err_count++;
      give_verdict();
   end
endmodule : tb_top
